//--- common/bcs_defines.svh
// Offsets, field positions, reset values and timing for the charger sequencer
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// Register offsets
`define BCS_ADDR_SET_ONE 8'h04
`define BCS_ADDR_SET_TWO 8'h05
`define BCS_ADDR_SET_THREE 8'h06
`define BCS_ADDR_PROGRESS 8'h08
`define BCS_ADDR_CONTROL 8'h0B
`define BCS_ADDR_FAULT 8'h0C
`define BCS_ADDR_SELECT 8'h0D

// Reset values
`define BCS_RST_SET_ONE 8'h00
`define BCS_RST_SET_TWO 8'h00
`define BCS_RST_SET_THREE 8'h00
`define BCS_RST_CONTROL_SEL 2'h0
`define BCS_RST_CONTROL_BIT 1'h0
`define BCS_RST_SELECT 8'h80

// Field positions
`define BCS_CHEM_HI 7
`define BCS_CHEM_LO 6
`define BCS_DUR_HI 3
`define BCS_DUR_LO 0
`define BCS_RECHG_BIT 7
`define BCS_FSEL_HI 6
`define BCS_FSEL_LO 5
`define BCS_CHGBIT 4
`define BCS_FSEL_CHARGER 2'h1
`define BCS_SEL_HI 7
`define BCS_SEL_LO 3
`define BCS_CTRL_WMASK 8'h70

// Timing
`define BCS_CLK_HZ 50000000
`define BCS_PULSE_ON_S 2
`define BCS_PULSE_OFF_S 58
`define BCS_PRECHG_LIMIT_MIN 30
`define BCS_PRECHG_LIMIT_S (`BCS_PRECHG_LIMIT_MIN * 60)
`define BCS_DUR_STEP_H 2
`define BCS_DUR_STEP_S (`BCS_DUR_STEP_H * 3600)

`endif

//--- common/bcs_pkg.sv
// Types shared by the charger sequencer and its bench
package bcs_pkg;

   typedef enum logic [3:0] {
      BCS_IDLE,
      BCS_NI_CONT,
      BCS_NI_PULSE,
      BCS_NI_REST,
      BCS_LI_TRICKLE,
      BCS_LI_PRE,
      BCS_LI_CC,
      BCS_LI_CV,
      BCS_LI_WAIT,
      BCS_DONE,
      BCS_STOP
   } bcs_phase_e;

   typedef enum logic [2:0] {
      BCS_DRV_OFF,
      BCS_DRV_TRICKLE,
      BCS_DRV_PRE,
      BCS_DRV_CC,
      BCS_DRV_CV
   } bcs_drive_e;

   typedef enum logic [1:0] {
      BCS_CHEM_NIMH,
      BCS_CHEM_LION,
      BCS_CHEM_LIFEPO4,
      BCS_CHEM_SUPERCAP
   } bcs_chem_e;

   // Comparator results from the analog side
   typedef struct packed {
      logic vcc_ok;
      logic vout_overvoltage;
      logic vout_above_wake;
      logic vout_reverse;
      logic temp_above_175;
      logic temp_above_160;
      logic battery_temp_window_fault;
      logic boost_running;
      logic bat_above_full;
      logic bat_above_ovp;
      logic bat_above_short;
      logic bat_above_lowv;
      logic bat_at_target;
      logic current_below_term;
      logic bat_below_recharge;
   } bcs_sense_s;

   typedef struct packed {
      bcs_phase_e phase;
      logic [25:0] presc;
      logic [16:0] secs;
      logic [7:0] set_one;
      logic [7:0] set_two;
      logic [7:0] set_three;
      logic [7:0] select;
      logic [1:0] func_sel;
      logic chg_bit;
      logic done_flag;
      logic alert_boost;
      logic alert_done;
      logic boost_q;
      logic tsd;
      logic short_f;
      logic ovp_f;
      logic [7:0] rdata;
      logic status_oe;
      logic power_off;
      bcs_drive_e drive;
   } bcs_state_s;

endpackage

//--- design/bcs_charger_seq.sv
// Backup charger sequencer: enable, charge phases, protection, status pin
`timescale 1ns/1ps
`default_nettype none
`include "bcs_defines.svh"

// How it works
// [R1] Status pin only pulls low or releases
// [R2] Select register bits 7..3 pick items
// [R3] Pin low if any selected item active
// [R4] Bit 7 live boost state, default on
// [R5] Bit 6 latched boost entered since read
// [R6] Bit 5 latched charge done since read
// [R7] Bits 4,3 thermal shutdown, temp window
// [R8] Switches off at 175, restart below 160
// [R9] Charger enable needs pin, 01b, OVP, VCC
// [R10] Charger mode only above boost wake level
// [R11] Charger off when output near battery
// [R12] Chemistry field picks charging profile
// [R13] Nickel full at start: skip, flag done
// [R14] Nickel timed continuous phase, then done
// [R15] No recharge: stop; enable toggle restarts
// [R16] Nickel recharge: pulses 2s on 58s off
// [R17] Nickel per-cell overvoltage stops, flags fault
// [R18] Lithium trickle below short threshold
// [R19] Lithium pre-charge at one fifth current
// [R20] Pre-charge over 30 minutes: short fault
// [R21] Lithium constant current, voltage, terminate
// [R22] Lithium recharge restarts below threshold
// [R23] Reading progress clears latched alerts
module bcs_charger_seq #(
   parameter int TICK_CYCLES = `BCS_CLK_HZ
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Pins and comparators
   input wire logic charger_enable_pin_i,
   input wire bcs_pkg::bcs_sense_s sense_i,
   // Register port
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Open-drain status pin
   input wire logic status_pin_i,
   output logic status_pin_o,
   output logic status_pin_oe_o,
   // Power stage control
   output logic power_off_o,
   output bcs_pkg::bcs_drive_e drive_o
);
   import bcs_pkg::*;

   localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);
   localparam logic [16:0] PULSE_ON = 17'(`BCS_PULSE_ON_S);
   localparam logic [16:0] PULSE_OFF = 17'(`BCS_PULSE_OFF_S);
   localparam logic [16:0] PRE_LIMIT = 17'(`BCS_PRECHG_LIMIT_S);
   localparam logic [16:0] DUR_STEP = 17'(`BCS_DUR_STEP_S);

   bcs_state_s st_reg;
   bcs_state_s st_next;

   // Continuous phase length in seconds, steps of two hours
   function automatic logic [16:0] cont_secs(input logic [3:0] dur);
      logic [16:0] steps;
      steps = {13'h0000, dur} + 17'h00001;
      cont_secs = 17'(steps * DUR_STEP);
   endfunction

   // Register read view
   function automatic logic [7:0] read_mux(input bcs_state_s s,
                                           input logic [7:0] addr,
                                           input logic mode);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         `BCS_ADDR_SET_ONE: v = s.set_one;
         `BCS_ADDR_SET_TWO: v = s.set_two;
         `BCS_ADDR_SET_THREE: v = s.set_three;
         `BCS_ADDR_PROGRESS: v = {s.done_flag, s.alert_boost,
                                  s.alert_done, s.boost_q, s.phase};
         `BCS_ADDR_CONTROL: v = {mode, s.func_sel, s.chg_bit,
                                 3'h0, s.done_flag};
         `BCS_ADDR_FAULT: v = {3'h0, s.tsd,
                               sense_i.battery_temp_window_fault,
                               s.short_f, s.ovp_f, 1'b0};
         `BCS_ADDR_SELECT: v = s.select;
         default: v = 8'h00;
      endcase
      read_mux = v;
   endfunction

   logic func_en;
   logic chg_mode;
   logic tick;
   logic hold;
   logic lith;
   logic recharge;
   logic [16:0] secs_inc;
   logic [4:0] items;

   always_comb begin
      st_next = st_reg;

      // Free running one-second tick
      tick = (st_reg.presc == TICK_LAST);
      st_next.presc = tick ? 26'h0000000 : st_reg.presc + 26'h0000001;

      // Register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `BCS_ADDR_SET_ONE: st_next.set_one = reg_wdata_i;
            `BCS_ADDR_SET_TWO: st_next.set_two = reg_wdata_i;
            `BCS_ADDR_SET_THREE: st_next.set_three = reg_wdata_i;
            `BCS_ADDR_CONTROL: begin
               st_next.func_sel = reg_wdata_i[`BCS_FSEL_HI:`BCS_FSEL_LO];
               st_next.chg_bit = reg_wdata_i[`BCS_CHGBIT];
            end
            `BCS_ADDR_SELECT: st_next.select = reg_wdata_i; // [R2]
            default: st_next.select = st_reg.select;
         endcase
      end

      func_en = charger_enable_pin_i && st_reg.chg_bit &&
                (st_reg.func_sel == `BCS_FSEL_CHARGER) &&
                !sense_i.vout_overvoltage && sense_i.vcc_ok; // [R9]
      chg_mode = func_en && sense_i.vout_above_wake; // [R10]

      // Thermal shutdown with hysteresis
      if (sense_i.temp_above_175) begin
         st_next.tsd = 1'b1; // [R8]
      end else if (!sense_i.temp_above_160) begin
         st_next.tsd = 1'b0; // [R8]
      end

      // Charging pauses; timers freeze meanwhile
      hold = !chg_mode || sense_i.vout_reverse || st_reg.tsd ||
             sense_i.battery_temp_window_fault; // [R11]
      lith = (bcs_chem_e'(st_reg.set_one[`BCS_CHEM_HI:`BCS_CHEM_LO])
              != BCS_CHEM_NIMH); // [R12]
      recharge = st_reg.set_three[`BCS_RECHG_BIT];
      secs_inc = (tick && !hold) ? st_reg.secs + 17'h00001 : st_reg.secs;

      // Disable clears phase, timer, done, short and overvoltage flags (not tsd), so a toggle restarts the cycle
      if (!func_en) begin
         st_next.phase = BCS_IDLE; // [R15]
         st_next.secs = 17'h00000;
         st_next.done_flag = 1'b0; // [R15]
         st_next.short_f = 1'b0;
         st_next.ovp_f = 1'b0;
      end else begin
         unique case (st_reg.phase)
            BCS_IDLE: begin
               st_next.secs = 17'h00000;
               if (chg_mode && !st_reg.tsd) begin
                  if (lith) begin
                     st_next.phase = BCS_LI_TRICKLE; // [R12]
                  end else if (sense_i.bat_above_full) begin
                     st_next.done_flag = 1'b1; // [R13]
                     st_next.phase = recharge ? BCS_NI_REST
                                              : BCS_DONE; // [R13]
                  end else begin
                     st_next.phase = BCS_NI_CONT; // [R14]
                  end
               end
            end
            BCS_NI_CONT: begin
               st_next.secs = secs_inc;
               if (sense_i.bat_above_ovp) begin
                  st_next.ovp_f = 1'b1; // [R17]
                  st_next.phase = BCS_STOP; // [R17]
               end else if (st_reg.secs >=
                            cont_secs(st_reg.set_two[`BCS_DUR_HI:
                                                     `BCS_DUR_LO])) begin
                  st_next.done_flag = 1'b1; // [R14]
                  st_next.secs = 17'h00000;
                  st_next.phase = recharge ? BCS_NI_REST
                                           : BCS_DONE; // [R15]
               end
            end
            BCS_NI_PULSE: begin
               st_next.secs = secs_inc;
               if (sense_i.bat_above_ovp) begin
                  st_next.ovp_f = 1'b1; // [R17]
                  st_next.phase = BCS_STOP;
               end else if (st_reg.secs >= PULSE_ON) begin
                  st_next.secs = 17'h00000;
                  st_next.phase = BCS_NI_REST; // [R16]
               end
            end
            BCS_NI_REST: begin
               st_next.secs = secs_inc;
               if (sense_i.bat_above_ovp) begin
                  st_next.ovp_f = 1'b1; // [R17]
                  st_next.phase = BCS_STOP;
               end else if (st_reg.secs >= PULSE_OFF) begin
                  st_next.secs = 17'h00000;
                  st_next.phase = BCS_NI_PULSE; // [R16]
               end
            end
            BCS_LI_TRICKLE: begin
               st_next.secs = 17'h00000;
               if (sense_i.bat_above_short) begin
                  st_next.phase = BCS_LI_PRE; // [R18]
               end
            end
            BCS_LI_PRE: begin
               st_next.secs = secs_inc;
               if (sense_i.bat_above_lowv) begin
                  st_next.secs = 17'h00000;
                  st_next.phase = BCS_LI_CC; // [R21]
               end else if (st_reg.secs >= PRE_LIMIT) begin
                  st_next.short_f = 1'b1; // [R20]
                  st_next.phase = BCS_STOP; // [R20]
               end
            end
            BCS_LI_CC: begin
               if (sense_i.bat_at_target) begin
                  st_next.phase = BCS_LI_CV; // [R21]
               end
            end
            BCS_LI_CV: begin
               if (sense_i.current_below_term && !hold) begin
                  st_next.done_flag = 1'b1; // [R21]
                  st_next.phase = recharge ? BCS_LI_WAIT
                                           : BCS_DONE; // [R15]
               end
            end
            BCS_LI_WAIT: begin
               if (sense_i.bat_below_recharge) begin
                  st_next.phase = BCS_LI_TRICKLE; // [R22]
               end
            end
            BCS_DONE: st_next.phase = BCS_DONE; // [R15]
            BCS_STOP: st_next.phase = BCS_STOP;
            default: st_next.phase = BCS_IDLE;
         endcase
      end

      // Drive code to the charger power stage
      if (hold) begin
         st_next.drive = BCS_DRV_OFF; // [R11]
      end else begin
         unique case (st_reg.phase)
            BCS_NI_CONT: st_next.drive = BCS_DRV_CC; // [R14]
            BCS_NI_PULSE: st_next.drive = BCS_DRV_CC; // [R16]
            BCS_LI_TRICKLE: st_next.drive = BCS_DRV_TRICKLE; // [R18]
            BCS_LI_PRE: st_next.drive = BCS_DRV_PRE; // [R19]
            BCS_LI_CC: st_next.drive = BCS_DRV_CC; // [R21]
            BCS_LI_CV: st_next.drive = BCS_DRV_CV; // [R21]
            default: st_next.drive = BCS_DRV_OFF;
         endcase
      end
      st_next.power_off = st_reg.tsd; // [R8]

      // Latched alerts: read clears, a new event wins
      st_next.boost_q = sense_i.boost_running;
      if (reg_rd_i && (reg_addr_i == `BCS_ADDR_PROGRESS)) begin
         st_next.alert_boost = 1'b0; // [R23]
         st_next.alert_done = 1'b0; // [R23]
      end
      if (sense_i.boost_running && !st_reg.boost_q) begin
         st_next.alert_boost = 1'b1; // [R5]
      end
      if (st_next.done_flag && !st_reg.done_flag) begin
         st_next.alert_done = 1'b1; // [R6]
      end

      // Status pin: any selected active item pulls low
      items = {st_reg.boost_q, st_reg.alert_boost, st_reg.alert_done,
               st_reg.tsd, sense_i.battery_temp_window_fault}; // [R4] [R7]
      st_next.status_oe = |(items &
                            st_reg.select[`BCS_SEL_HI:`BCS_SEL_LO]); // [R3]

      if (reg_rd_i) begin
         st_next.rdata = read_mux(st_reg, reg_addr_i, chg_mode);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         st_reg <= '0;
         st_reg.phase <= BCS_IDLE;
         st_reg.drive <= BCS_DRV_OFF;
         st_reg.set_one <= `BCS_RST_SET_ONE;
         st_reg.set_two <= `BCS_RST_SET_TWO;
         st_reg.set_three <= `BCS_RST_SET_THREE;
         st_reg.func_sel <= `BCS_RST_CONTROL_SEL;
         st_reg.chg_bit <= `BCS_RST_CONTROL_BIT;
         st_reg.select <= `BCS_RST_SELECT; // [R4]
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_o = st_reg.rdata;
   assign status_pin_o = 1'b0; // [R1]
   assign status_pin_oe_o = st_reg.status_oe; // [R1]
   assign power_off_o = st_reg.power_off;
   assign drive_o = st_reg.drive;

endmodule
`default_nettype wire

//--- sim/bcs_charger_seq_chk.sv
// Port-level checker for the charger sequencer
`timescale 1ns/1ps
`default_nettype none
module bcs_charger_seq_chk #(
   parameter int TICK_CYCLES = 4
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Observed inputs
   input wire logic charger_enable_pin_i,
   input wire bcs_pkg::bcs_sense_s sense_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   // Observed outputs
   input wire logic status_pin_o,
   input wire logic status_pin_oe_o,
   input wire logic power_off_o,
   input wire bcs_pkg::bcs_drive_e drive_o
);
   import bcs_pkg::*;
   logic [4:0] sel_reg;

   // Shadow of the item-select bits
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) sel_reg <= 5'h10;
      else if (reg_wr_i && reg_addr_i == 8'h0D) sel_reg <= reg_wdata_i[7:3];
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   AST_OD_LOW: assert property (status_pin_o == 1'b0)
      else $error("status pin driven high");
   AST_SEL_NONE: assert property ((sel_reg == 5'h00) [*4] |->
      !status_pin_oe_o) else $error("pin low with no item");
   AST_SEL_BOOST: assert property ((sel_reg[4] && sense_i.boost_running)
      [*4] |-> status_pin_oe_o) else $error("boost item not shown");
   AST_SEL_TEMP: assert property ((sel_reg[0] &&
      sense_i.battery_temp_window_fault) [*4] |-> status_pin_oe_o)
      else $error("temp window item not shown");
   AST_TSD_ON: assert property ($rose(sense_i.temp_above_175) |->
      ##[1:3] power_off_o) else $error("no shutdown");
   AST_TSD_HOLD: assert property (sense_i.temp_above_160 [*4] ##0
      $past(power_off_o, 2) |-> power_off_o) else $error("early restart");
   AST_TSD_OFF: assert property ((!sense_i.temp_above_160 &&
      !sense_i.temp_above_175) [*3] |-> !power_off_o)
      else $error("no restart");
   AST_EN_OFF: assert property ((!charger_enable_pin_i ||
      !sense_i.vcc_ok || sense_i.vout_overvoltage) [*3] |->
      drive_o == BCS_DRV_OFF) else $error("drive while disabled");
   AST_WAKE_OFF: assert property (!sense_i.vout_above_wake [*3] |->
      drive_o == BCS_DRV_OFF) else $error("drive below wake level");
   AST_REV_OFF: assert property (sense_i.vout_reverse [*3] |->
      drive_o == BCS_DRV_OFF) else $error("drive in reverse");
endmodule

bind bcs_charger_seq bcs_charger_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .charger_enable_pin_i(charger_enable_pin_i), .sense_i(sense_i),
   .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .status_pin_o(status_pin_o), .status_pin_oe_o(status_pin_oe_o),
   .power_off_o(power_off_o), .drive_o(drive_o));
`default_nettype wire

//--- sim/bcs_status_model.sv
// Host-side status line with its pull-up
`timescale 1ns/1ps
`default_nettype none
module bcs_status_model (
   // Device pin side
   input wire logic status_pin_o,
   input wire logic status_pin_oe_o,
   // Host side
   output logic status_level_o
);
   // Pull-up wins when released
   assign status_level_o = status_pin_oe_o ? status_pin_o : 1'b1;
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Register-level regression for the charger sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bcs_pkg::*;
   localparam int TICK = 4;
   logic ref_clk_i, reset_i, pin, wr, rd, lvl, st_o, st_oe, poff;
   logic [7:0] addr, wdata, rdata, q;
   bcs_sense_s sense;
   bcs_drive_e drive;
   int error_cnt, checks_done, n;

   bcs_charger_seq #(.TICK_CYCLES(TICK)) dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .charger_enable_pin_i(pin), .sense_i(sense),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .status_pin_i(lvl), .status_pin_o(st_o), .status_pin_oe_o(st_oe),
      .power_off_o(poff), .drive_o(drive));
   bcs_status_model u_pin (.status_pin_o(st_o), .status_pin_oe_o(st_oe),
      .status_level_o(lvl));

   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      step(1);
      wr = 1'b1;
      addr = a;
      wdata = d;
      step(1);
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      step(1);
      rd = 1'b1;
      addr = a;
      step(1);
      rd = 1'b0;
      d = rdata;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(d, exp);
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      step(50000);
      error_cnt++;
      end_sim;
   end

   initial begin
      reset_i = 1'b1;
      pin = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      sense = '0;
      error_cnt = 0;
      checks_done = 0;
      step(2);
      reset_i = 1'b0;
      rchk(8'h0D, 8'h80);
      sense.boost_running = 1'b1;
      step(4);
      chk(8'(lvl), 8'h00);
      sense.boost_running = 1'b0;
      wr_reg(8'h0D, 8'h40);
      step(4);
      chk(8'(lvl), 8'h00);
      rchk(8'h08, 8'h40);
      step(4);
      chk(8'(lvl), 8'h01);
      wr_reg(8'h0D, 8'h18);
      sense.battery_temp_window_fault = 1'b1;
      step(4);
      chk(8'(lvl), 8'h00);
      sense.battery_temp_window_fault = 1'b0;
      sense.temp_above_175 = 1'b1;
      sense.temp_above_160 = 1'b1;
      step(4);
      chk(8'(poff), 8'h01);
      chk(8'(lvl), 8'h00);
      rchk(8'h0C, 8'h10);
      sense.temp_above_175 = 1'b0;
      step(6);
      chk(8'(poff), 8'h01);
      wr_reg(8'h0D, 8'h00);
      step(4);
      chk(8'(lvl), 8'h01);
      sense.temp_above_160 = 1'b0;
      step(4);
      chk(8'(poff), 8'h00);
      pin = 1'b1;
      sense.vcc_ok = 1'b1;
      sense.vout_above_wake = 1'b1;
      wr_reg(8'h0B, 8'h50);
      step(4);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      wr_reg(8'h0B, 8'h30);
      step(4);
      chk(8'(drive), 8'(BCS_DRV_CC));
      rchk(8'h08, 8'h01);
      rchk(8'h0B, 8'hB0);
      sense.vout_reverse = 1'b1;
      step(4);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      sense.vout_reverse = 1'b0;
      sense.vout_above_wake = 1'b0;
      step(4);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      sense.vout_above_wake = 1'b1;
      wr_reg(8'h0D, 8'h20);
      step(7200 * TICK - 80);
      chk(8'(drive), 8'(BCS_DRV_CC));
      chk(8'(lvl), 8'h01);
      step(160);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      chk(8'(lvl), 8'h00);
      rd_reg(8'h08, q);
      chk(q & 8'hE0, 8'hA0);
      wr_reg(8'h0B, 8'h20);
      wr_reg(8'h0B, 8'h30);
      step(4);
      rchk(8'h08, 8'h01);
      sense.bat_above_ovp = 1'b1;
      step(4);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      rchk(8'h0C, 8'h02);
      sense.bat_above_ovp = 1'b0;
      wr_reg(8'h0B, 8'h20);
      sense.bat_above_full = 1'b1;
      wr_reg(8'h0B, 8'h30);
      step(4);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      rd_reg(8'h08, q);
      chk(q & 8'h80, 8'h80);
      sense.bat_above_full = 1'b0;
      wr_reg(8'h0B, 8'h20);
      wr_reg(8'h04, 8'h40);
      wr_reg(8'h06, 8'h80);
      rchk(8'h06, 8'h80);
      wr_reg(8'h0B, 8'h30);
      step(4);
      chk(8'(drive), 8'(BCS_DRV_TRICKLE));
      sense.bat_above_short = 1'b1;
      step(4);
      chk(8'(drive), 8'(BCS_DRV_PRE));
      step(1800 * TICK - 40);
      chk(8'(drive), 8'(BCS_DRV_PRE));
      step(100);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      rchk(8'h0C, 8'h04);
      wr_reg(8'h0B, 8'h20);
      sense.bat_above_lowv = 1'b1;
      wr_reg(8'h0B, 8'h30);
      step(6);
      chk(8'(drive), 8'(BCS_DRV_CC));
      sense.bat_at_target = 1'b1;
      step(4);
      chk(8'(drive), 8'(BCS_DRV_CV));
      sense.current_below_term = 1'b1;
      step(4);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      rd_reg(8'h08, q);
      chk(q & 8'h8F, 8'h88);
      sense.bat_at_target = 1'b0;
      sense.current_below_term = 1'b0;
      sense.bat_below_recharge = 1'b1;
      step(6);
      chk(8'(drive), 8'(BCS_DRV_CC));
      // Nickel full with recharge: rest first, then one short pulse
      wr_reg(8'h0B, 8'h20);
      sense.bat_above_full = 1'b1;
      wr_reg(8'h04, 8'h00);
      wr_reg(8'h0B, 8'h30);
      step(200);
      chk(8'(drive), 8'(BCS_DRV_OFF));
      n = 0;
      repeat (80) begin
         step(1);
         if (drive == BCS_DRV_CC) n++;
      end
      chk(8'(n >= 5 && n <= 9), 8'h01);
      end_sim;
   end
endmodule
`default_nettype wire
